/* hdl/qdc_defines.svh */
// Constants of the quad DAC command decoder: frame layout, codes, defaults.
// Assumes inclusion by its bare name from the package and the design files.
`ifndef QDC_DEFINES_SVH
`define QDC_DEFINES_SVH

// =====================================================================
// Frame layout
`define QDC_FRAME_BITS   5'd24
`define QDC_CNT_OVER     5'd25
`define QDC_BIT_RW       23
`define QDC_BIT_ZERO     22
`define QDC_TYPE_HI      21
`define QDC_TYPE_LO      19
`define QDC_CHAN_HI      18
`define QDC_CHAN_LO      16

// =====================================================================
// Register type and channel codes
`define QDC_TYPE_FUNC    3'h0
`define QDC_TYPE_DATA    3'h2
`define QDC_TYPE_CGAIN   3'h3
`define QDC_TYPE_FGAIN   3'h4
`define QDC_TYPE_OFFS    3'h5
`define QDC_CHAN_ALL     3'h4
`define QDC_FN_NOP       3'h0
`define QDC_FN_CTRL      3'h1
`define QDC_FN_CLEAR     3'h4
`define QDC_FN_LOAD      3'h5

// =====================================================================
// Function control bit positions
`define QDC_FC_GND_ADJ   5
`define QDC_FC_DIR1      4
`define QDC_FC_VAL1      3
`define QDC_FC_DIR0      2
`define QDC_FC_VAL0      1
`define QDC_FC_SDO_DIS   0

// =====================================================================
// Reset values and field widths
`define QDC_FC_RESET     6'h00
`define QDC_CLEAR_CODE   16'h0000
`define QDC_CG_W         2
`define QDC_FG_W         6
`define QDC_OF_W         8

`endif

/* hdl/qdc_pkg.sv */
// Types shared by the quad DAC command decoder and its channel bank.
// Assumes qdc_defines.svh is on the include path.
`include "qdc_defines.svh"

package qdc_pkg;

  // ===================================================================
  // Per-channel register bank state
  typedef struct packed {
    logic [3:0][15:0]          in_r;
    logic [3:0][15:0]          dac;
    logic [3:0][`QDC_CG_W-1:0] cg;
    logic [3:0][`QDC_FG_W-1:0] fg;
    logic [3:0][`QDC_OF_W-1:0] ofs;
    logic [15:0]               rdata;
  } qdc_bank_t;

  // ===================================================================
  // Decoder state
  typedef struct packed {
    logic        sclk_s1;
    logic        sclk_s2;
    logic        sclk_s3;
    logic        frm_s1;
    logic        frm_s2;
    logic        frm_s3;
    logic        sdin_s1;
    logic        sdin_s2;
    logic        load_strobe_n_s1;
    logic        load_strobe_n_s2;
    logic        load_strobe_n_s3;
    logic        clr_s1;
    logic        clr_s2;
    logic        clr_s3;
    logic [1:0]  pin_s1;
    logic [1:0]  pin_s2;
    logic [23:0] shift;
    logic [4:0]  cnt;
    logic [23:0] out_sh;
    logic        rd_pend;
    logic [7:0]  rd_hdr;
    logic [5:0]  fc;
    logic        serial_out;
    logic        sdo_oe;
    logic        wr;
    logic [2:0]  wr_type;
    logic [3:0]  wr_mask;
    logic [15:0] wr_data;
    logic        direct;
    logic        load_all;
    logic        clear_all;
  } qdc_dec_t;

endpackage

/* hdl/qdc_bank_if.sv */
// Carrier between the command decoder and the channel register bank.
// Assumes both ends share one clock.
interface qdc_bank_if;
  logic             wr;
  logic [2:0]       wr_type;
  logic [3:0]       wr_mask;
  logic [15:0]      wr_data;
  logic             direct;
  logic             load_all;
  logic             clear_all;
  logic [2:0]       rd_type;
  logic [1:0]       rd_chan;
  logic [15:0]      rd_data;
  logic [3:0][15:0] dac_code;

  modport ctrl (
    output wr, wr_type, wr_mask, wr_data, direct, load_all, clear_all,
    output rd_type, rd_chan,
    input  rd_data, dac_code
  );
  modport bank (
    input  wr, wr_type, wr_mask, wr_data, direct, load_all, clear_all,
    input  rd_type, rd_chan,
    output rd_data, dac_code
  );
endinterface

/* hdl/qdc_bank.sv */
// Channel register bank: input, DAC, gain and offset words of four channels.
// Assumes one-cycle command pulses from the decoder on the same clock.
`include "qdc_defines.svh"

module qdc_bank (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // Decoder side
  qdc_bank_if.bank  bus
);
  import qdc_pkg::*;

  qdc_bank_t q;
  qdc_bank_t d;

  assign bus.rd_data  = q.rdata;
  assign bus.dac_code = q.dac;

  // ===================================================================
  // Next state
  always_comb begin
    d = q;
    for (int c = 0; c < 4; c++) begin
      if (bus.wr && bus.wr_mask[c]) begin
        case (bus.wr_type)
          `QDC_TYPE_DATA: begin
            d.in_r[c] = bus.wr_data;
            if (bus.direct) begin
              d.dac[c] = bus.wr_data;
            end
          end
          `QDC_TYPE_CGAIN: d.cg[c]  = bus.wr_data[`QDC_CG_W-1:0];
          `QDC_TYPE_FGAIN: d.fg[c]  = bus.wr_data[`QDC_FG_W-1:0];
          `QDC_TYPE_OFFS:  d.ofs[c] = bus.wr_data[`QDC_OF_W-1:0];
          default: ;
        endcase
      end
      if (bus.load_all) begin
        d.dac[c] = d.in_r[c];
      end
      // Clear wins over a load in the same cycle
      if (bus.clear_all) begin
        d.in_r[c] = `QDC_CLEAR_CODE;
        d.dac[c]  = `QDC_CLEAR_CODE;
      end
    end
    case (bus.rd_type)
      `QDC_TYPE_DATA:  d.rdata = q.in_r[bus.rd_chan];
      `QDC_TYPE_CGAIN: d.rdata = {14'h0000, q.cg[bus.rd_chan]};
      `QDC_TYPE_FGAIN: d.rdata = {10'h000, q.fg[bus.rd_chan]};
      `QDC_TYPE_OFFS:  d.rdata = {8'h00, q.ofs[bus.rd_chan]};
      default:         d.rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

/* hdl/qdc_decoder.sv */
// Quad DAC serial command decoder: frame capture, function register,
// auxiliary pins, readback shifter and update control.
// Assumes all pins are asynchronous to i_clk, serial clock much slower.
`include "qdc_defines.svh"

module qdc_decoder (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  // Serial link
  input  wire logic                  i_sclk,
  input  wire logic                  i_frame_n,
  input  wire logic                  i_sdin,
  output logic                       o_serial_out,
  output logic                       o_serial_out_oe,
  // Update pins
  input  wire logic                  i_load_strobe_n,
  input  wire logic                  i_clear_n,
  // Auxiliary pins
  input  wire logic                  i_aux_io_pin0,
  output logic                       o_aux_io_pin0,
  output logic                       o_aux_io_pin0_oe,
  input  wire logic                  i_aux_io_pin1,
  output logic                       o_aux_io_pin1,
  output logic                       o_aux_io_pin1_oe,
  // Analog side controls
  output logic                       o_gnd_offset_adj,
  output logic [3:0][15:0]           o_dac_code
);
  import qdc_pkg::*;

  qdc_dec_t   q;
  qdc_dec_t   d;
  qdc_bank_if bank_bus ();

  // ===================================================================
  // Channel bank
  qdc_bank u_bank (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .bus       (bank_bus.bank)
  );

  assign bank_bus.wr        = q.wr;
  assign bank_bus.wr_type   = q.wr_type;
  assign bank_bus.wr_mask   = q.wr_mask;
  assign bank_bus.wr_data   = q.wr_data;
  assign bank_bus.direct    = q.direct;
  assign bank_bus.load_all  = q.load_all;
  assign bank_bus.clear_all = q.clear_all;
  assign bank_bus.rd_type   = q.rd_hdr[5:3];
  assign bank_bus.rd_chan   = q.rd_hdr[1:0];

  // ===================================================================
  // Outputs
  assign o_serial_out     = q.serial_out;
  assign o_serial_out_oe  = q.sdo_oe;
  assign o_aux_io_pin0    = q.fc[`QDC_FC_VAL0];
  assign o_aux_io_pin0_oe = q.fc[`QDC_FC_DIR0];
  assign o_aux_io_pin1    = q.fc[`QDC_FC_VAL1];
  assign o_aux_io_pin1_oe = q.fc[`QDC_FC_DIR1];
  assign o_gnd_offset_adj = q.fc[`QDC_FC_GND_ADJ];
  assign o_dac_code       = bank_bus.dac_code;

  // ===================================================================
  // Decode helpers
  logic        sclk_fall;
  logic        sclk_rise;
  logic        frm_fall;
  logic        frm_rise;
  logic        frm_low;
  logic        load_strobe_n_fall;
  logic        clr_fall;
  logic        word_ok;
  logic [2:0]  w_type;
  logic [2:0]  w_chan;
  logic [15:0] w_data;
  logic [3:0]  w_mask;
  logic [15:0] fc_rb;
  logic [15:0] rb_data;

  assign sclk_fall = q.sclk_s3 & ~q.sclk_s2;
  assign sclk_rise = ~q.sclk_s3 & q.sclk_s2;
  assign frm_fall  = q.frm_s3 & ~q.frm_s2;
  assign frm_rise  = ~q.frm_s3 & q.frm_s2;
  assign frm_low   = ~q.frm_s2;
  assign load_strobe_n_fall = q.load_strobe_n_s3 & ~q.load_strobe_n_s2;
  assign clr_fall  = q.clr_s3 & ~q.clr_s2;

  // Only a word of exactly 24 edges with bit 22 clear is acted on
  assign word_ok = (q.cnt == `QDC_FRAME_BITS) &&
                   !q.shift[`QDC_BIT_ZERO];
  assign w_type  = q.shift[`QDC_TYPE_HI:`QDC_TYPE_LO];
  assign w_chan  = q.shift[`QDC_CHAN_HI:`QDC_CHAN_LO];
  assign w_data  = q.shift[15:0];

  always_comb begin
    case (w_chan)
      3'h0:          w_mask = 4'h1;
      3'h1:          w_mask = 4'h2;
      3'h2:          w_mask = 4'h4;
      3'h3:          w_mask = 4'h8;
      `QDC_CHAN_ALL: w_mask = 4'hf;
      default:       w_mask = 4'h0;
    endcase
  end

  // Input pins report the live level, output pins the written value
  assign fc_rb = {10'h000,
                  q.fc[`QDC_FC_GND_ADJ],
                  q.fc[`QDC_FC_DIR1],
                  q.fc[`QDC_FC_DIR1] ? q.fc[`QDC_FC_VAL1] : q.pin_s2[1],
                  q.fc[`QDC_FC_DIR0],
                  q.fc[`QDC_FC_DIR0] ? q.fc[`QDC_FC_VAL0] : q.pin_s2[0],
                  q.fc[`QDC_FC_SDO_DIS]};

  always_comb begin
    if (q.rd_hdr[5:3] == `QDC_TYPE_FUNC) begin
      rb_data = (q.rd_hdr[2:0] == `QDC_FN_CTRL) ? fc_rb : 16'h0000;
    end else if (q.rd_hdr[2]) begin
      // A read of all channels at once names no single word
      rb_data = 16'h0000;
    end else begin
      rb_data = bank_bus.rd_data;
    end
  end

  // ===================================================================
  // Next state
  always_comb begin
    d = q;
    d.sclk_s1   = i_sclk;
    d.sclk_s2   = q.sclk_s1;
    d.sclk_s3   = q.sclk_s2;
    d.frm_s1    = i_frame_n;
    d.frm_s2    = q.frm_s1;
    d.frm_s3    = q.frm_s2;
    d.sdin_s1   = i_sdin;
    d.sdin_s2   = q.sdin_s1;
    d.load_strobe_n_s1   = i_load_strobe_n;
    d.load_strobe_n_s2   = q.load_strobe_n_s1;
    d.load_strobe_n_s3   = q.load_strobe_n_s2;
    d.clr_s1    = i_clear_n;
    d.clr_s2    = q.clr_s1;
    d.clr_s3    = q.clr_s2;
    d.pin_s1    = {i_aux_io_pin1, i_aux_io_pin0};
    d.pin_s2    = q.pin_s1;
    d.wr        = 1'b0;
    d.load_all  = 1'b0;
    d.clear_all = 1'b0;

    // Frame start: count restarts, pending readback is loaded
    if (frm_fall) begin
      d.cnt    = 5'd0;
      d.out_sh = q.rd_pend ? {q.rd_hdr, rb_data} : 24'h000000;
      d.rd_pend = 1'b0;
    end else if (frm_low) begin
      if (sclk_fall) begin
        d.shift = {q.shift[22:0], q.sdin_s2};
        if (q.cnt != `QDC_CNT_OVER) begin
          d.cnt = q.cnt + 5'd1;
        end
      end
      // Change on rising edges so the host samples a settled bit
      if (sclk_rise && q.cnt != 5'd0) begin
        d.out_sh = {q.out_sh[22:0], 1'b0};
      end
    end

    // Frame end: act on a valid word
    if (frm_rise && word_ok) begin
      if (q.shift[`QDC_BIT_RW]) begin
        d.rd_pend = 1'b1;
        d.rd_hdr  = q.shift[23:16];
      end else if (w_type == `QDC_TYPE_FUNC) begin
        case (w_chan)
          `QDC_FN_NOP: ;
          `QDC_FN_CTRL: begin
            d.fc[`QDC_FC_GND_ADJ] = w_data[`QDC_FC_GND_ADJ];
            d.fc[`QDC_FC_DIR1]    = w_data[`QDC_FC_DIR1];
            d.fc[`QDC_FC_DIR0]    = w_data[`QDC_FC_DIR0];
            if (w_data[`QDC_FC_DIR1]) begin
              d.fc[`QDC_FC_VAL1] = w_data[`QDC_FC_VAL1];
            end
            if (w_data[`QDC_FC_DIR0]) begin
              d.fc[`QDC_FC_VAL0] = w_data[`QDC_FC_VAL0];
            end
            d.fc[`QDC_FC_SDO_DIS] = w_data[`QDC_FC_SDO_DIS];
          end
          `QDC_FN_CLEAR: d.clear_all = 1'b1;
          `QDC_FN_LOAD:  d.load_all  = 1'b1;
          default: ;
        endcase
      end else if (w_type >= `QDC_TYPE_DATA &&
                   w_type <= `QDC_TYPE_OFFS) begin
        d.wr      = 1'b1;
        d.wr_type = w_type;
        d.wr_mask = w_mask;
        d.wr_data = w_data;
        d.direct  = ~q.load_strobe_n_s2;
      end
    end

    if (load_strobe_n_fall) begin
      d.load_all = 1'b1;
    end
    if (clr_fall) begin
      d.clear_all = 1'b1;
    end

    d.serial_out    = d.out_sh[23];
    d.sdo_oe = ~q.frm_s2 & ~q.fc[`QDC_FC_SDO_DIS];
  end

  // ===================================================================
  // State register; frame, load and clear pins idle high so their syncs reset high
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q         <= '0;
      q.frm_s1  <= 1'b1;
      q.frm_s2  <= 1'b1;
      q.frm_s3  <= 1'b1;
      q.load_strobe_n_s1 <= 1'b1;
      q.load_strobe_n_s2 <= 1'b1;
      q.load_strobe_n_s3 <= 1'b1;
      q.clr_s1  <= 1'b1;
      q.clr_s2  <= 1'b1;
      q.clr_s3  <= 1'b1;
      q.cnt     <= `QDC_CNT_OVER;
      q.fc      <= `QDC_FC_RESET;
    end else begin
      q <= d;
    end
  end

endmodule

/* testbench/qdc_decoder_properties.sv */
// Pin-level checker for the quad DAC command decoder.
// Assumes binding into qdc_decoder; one clock domain, async reset.
module qdc_decoder_properties (
  // Clock and reset
  input wire logic             i_clk,
  input wire logic             i_sys_rst,
  // Inputs
  input wire logic             i_sclk,
  input wire logic             i_frame_n,
  input wire logic             i_sdin,
  input wire logic             i_load_strobe_n,
  input wire logic             i_clear_n,
  input wire logic             i_aux_io_pin0,
  input wire logic             i_aux_io_pin1,
  // Outputs
  input wire logic             o_serial_out,
  input wire logic             o_serial_out_oe,
  input wire logic             o_aux_io_pin0,
  input wire logic             o_aux_io_pin0_oe,
  input wire logic             o_aux_io_pin1,
  input wire logic             o_aux_io_pin1_oe,
  input wire logic             o_gnd_offset_adj,
  input wire logic [3:0][15:0] o_dac_code
);
  // ==========================================
  // Properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  chk_oe_idle:
    assert property (i_frame_n [*6] |-> !o_serial_out_oe)
    else $error("serial out enabled outside frame");
  // Quiet link and steady pins leave the codes alone
  chk_dac_hold:
    assert property ((i_frame_n && i_clear_n && $stable(i_load_strobe_n))
      [*8] |=> $stable(o_dac_code)) else $error("dac code moved");
  chk_clear_pin:
    assert property ($fell(i_clear_n) |-> ##[4:6] (o_dac_code == '0))
    else $error("clear pin did not clear");
  chk_gnd_hold:
    assert property (i_frame_n [*8] |=> $stable(o_gnd_offset_adj))
    else $error("ground adjust moved");
  chk_pin0_hold:
    assert property (i_frame_n [*8] |=>
      $stable({o_aux_io_pin0_oe, o_aux_io_pin0})) else $error("pin0 moved");
  chk_pin1_hold:
    assert property (i_frame_n [*8] |=>
      $stable({o_aux_io_pin1_oe, o_aux_io_pin1})) else $error("pin1 moved");
  chk_sdo_hold:
    assert property ((i_sclk && !i_frame_n) [*8] |=> $stable(o_serial_out))
    else $error("serial out moved while clock high");
  chk_reset_zero:
    assert property ($fell(i_sys_rst) |-> (o_dac_code == '0)
      && !(o_gnd_offset_adj || o_aux_io_pin0_oe || o_aux_io_pin1_oe))
    else $error("outputs not at defaults after reset");
endmodule

bind qdc_decoder qdc_decoder_properties u_qdc_decoder_properties (
  .i_clk, .i_sys_rst, .i_sclk, .i_frame_n, .i_sdin, .i_load_strobe_n,
  .i_clear_n, .i_aux_io_pin0, .i_aux_io_pin1, .o_serial_out,
  .o_serial_out_oe, .o_aux_io_pin0, .o_aux_io_pin0_oe, .o_aux_io_pin1,
  .o_aux_io_pin1_oe, .o_gnd_offset_adj, .o_dac_code
);

/* testbench/qdc_host_model.sv */
// Host serial port model: sends command frames, captures readback.
// Assumes the bench clock i_clk; link clock is 20 of its cycles.
module qdc_host_model (
  // Clock
  input  wire logic i_clk,
  // Serial link
  output logic      o_sclk,
  output logic      o_frame_n,
  output logic      o_sdin,
  input  wire logic i_serial_out,
  input  wire logic i_serial_out_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic oe_seen;

  initial begin
    o_sclk = 1'b1;
    o_frame_n = 1'b1;
    o_sdin = 1'b0;
    oe_seen = 1'b0;
  end

  task automatic half();
    repeat (10) @(negedge i_clk);
  endtask

  // ==========================================
  // Frame: nbits of w MSB first, readback sampled on falling edges
  task automatic frame(input logic [23:0] w, input int nbits,
                       output logic [23:0] rd);
    rd = '0;
    oe_seen = 1'b0;
    o_frame_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      o_sdin = w[23 - (i % 24)];
      half();
      o_sclk = 1'b0;
      rd = {rd[22:0], i_serial_out};
      oe_seen = oe_seen | i_serial_out_oe;
      half();
      o_sclk = 1'b1;
    end
    half();
    o_frame_n = 1'b1;
    // Released data line must not keep showing the last bit
    o_sdin = ~o_sdin;
    half();
  endtask
endmodule

/* testbench/qdc_decoder_tb_top.sv */
// Self-checking bench for qdc_decoder, driven through its serial link.
// Assumes the host model and the bound checker are compiled alongside.
module qdc_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic             sclk, frame_n, sdin, serial_out, sdo_oe;
  logic             load_n = 1'b0;
  logic             clear_n = 1'b1;
  logic [1:0]       pin_drv = 2'b01;
  logic             pin0, pin1, aux0, aux0_oe, aux1, aux1_oe, gnd_adj;
  logic [3:0][15:0] dac_code;
  logic [23:0]      rd;
  int               bad_count = 0;
  int               samples_checked = 0;
  logic [3:0][15:0] vals = {16'hd00d, 16'hc00c, 16'hb00b, 16'ha00a};
  logic [2:0]       gtype [3] = '{3'h3, 3'h4, 3'h5};
  logic [15:0]      gmask [3] = '{16'h0003, 16'h003f, 16'h00ff};
  logic [23:0]      bad_w [8] = '{24'h12ffff, 24'h12ffff, 24'h52ffff,
    24'h0affff, 24'h32ffff, 24'h02ffff, 24'h07ffff, 24'h00ffff};
  int               bad_n [8] = '{23, 25, 24, 24, 24, 24, 24, 24};

  always #2 clk = ~clk;
  // Aux pins resolve between the device drive and the bench drive
  assign pin0 = aux0_oe ? aux0 : pin_drv[0];
  assign pin1 = aux1_oe ? aux1 : pin_drv[1];

  qdc_host_model u_qdc_host_model (.i_clk(clk), .o_sclk(sclk),
    .o_frame_n(frame_n), .o_sdin(sdin), .i_serial_out(serial_out),
    .i_serial_out_oe(sdo_oe));
  qdc_decoder u_qdc_decoder (.i_clk(clk), .i_sys_rst(sys_rst),
    .i_sclk(sclk), .i_frame_n(frame_n), .i_sdin(sdin),
    .o_serial_out(serial_out), .o_serial_out_oe(sdo_oe),
    .i_load_strobe_n(load_n), .i_clear_n(clear_n),
    .i_aux_io_pin0(pin0), .o_aux_io_pin0(aux0), .o_aux_io_pin0_oe(aux0_oe),
    .i_aux_io_pin1(pin1), .o_aux_io_pin1(aux1), .o_aux_io_pin1_oe(aux1_oe),
    .o_gnd_offset_adj(gnd_adj), .o_dac_code(dac_code));

  // ==========================================
  // Shared tasks
  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send(input logic [23:0] w);
    u_qdc_host_model.frame(w, 24, rd);
  endtask
  task automatic chk_dac(input logic [3:0][15:0] e);
    for (int i = 0; i < 4; i++) check("dac", {8'h00, dac_code[i]},
      {8'h00, e[i]});
  endtask
  task automatic chk_ctrl(input logic [4:0] e);
    check("ctrl", {19'h0, gnd_adj, aux1_oe, aux1, aux0_oe, aux0}, {19'h0, e});
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================
  // Tests
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    chk_ctrl(5'h00);
    check("sdo_oe", {23'h0, sdo_oe}, 24'h0);
    chk_dac('0);
    $display("test defaults done");
    send(24'h01ffba);
    chk_ctrl(5'h1c);
    send(24'h81ffff);
    send(24'h000000);
    check("rd_ctrl", rd, 24'h81003a);
    check("oe_seen", {23'h0, u_qdc_host_model.oe_seen}, 24'h1);
    send(24'h01000a);
    chk_ctrl(5'h04);
    send(24'h81ffff);
    send(24'h000000);
    check("rd_pins", rd, 24'h810002);
    $display("test function register done");
    for (int i = 0; i < 4; i++) send({5'b00010, i[2:0], vals[i]});
    chk_dac(vals);
    send(24'h920000);
    send(24'h000000);
    check("rd_data", rd, {8'h92, vals[2]});
    send({8'h14, 16'h5555});
    chk_dac({4{16'h5555}});
    for (int i = 0; i < 3; i++) begin
      send({2'b00, gtype[i], 3'h1, 16'hffff});
      send({2'b10, gtype[i], 3'h1, 16'h0000});
      send(24'h000000);
      check("rd_gain", rd, {2'b10, gtype[i], 3'h1, gmask[i]});
    end
    $display("test registers done");
    load_n = 1'b1;
    send({8'h10, 16'h1234});
    chk_dac({4{16'h5555}});
    send(24'h05ffff);
    chk_dac({16'h5555, 16'h5555, 16'h5555, 16'h1234});
    send({8'h11, 16'h4321});
    load_n = 1'b0;
    repeat (10) @(negedge clk);
    chk_dac({16'h5555, 16'h5555, 16'h4321, 16'h1234});
    send(24'h04ffff);
    chk_dac('0);
    send({8'h14, 16'h7777});
    clear_n = 1'b0;
    repeat (10) @(negedge clk);
    chk_dac('0);
    clear_n = 1'b1;
    $display("test update and clear done");
    send({8'h14, 16'h6666});
    for (int i = 0; i < 8; i++) begin
      u_qdc_host_model.frame(bad_w[i], bad_n[i], rd);
      chk_dac({4{16'h6666}});
      chk_ctrl(5'h04);
    end
    $display("test refused frames done");
    send(24'h010001);
    send(24'h000000);
    check("oe_off", {23'h0, u_qdc_host_model.oe_seen}, 24'h0);
    $display("test output disable done");
    test_done();
  end

  initial begin
    #200000;
    bad_count++;
    test_done();
  end
endmodule
